/* p4pu_bench.sv */
// p4pu_bench: self-checking bench for the port 4 pull-up enable block.
// assumes p4pu_pkg and p4pu_top are compiled first; drives every port itself.
`timescale 1ns/10ps
module p4pu_bench;
	import p4pu_pkg::*;

	// one comparison, counted, mismatch reported at once
	`define CHK(what, expv, gotv) begin \
		cmp_count++; \
		if ((gotv) !== (expv)) begin \
			err_total++; \
			$display("BAD %s exp %h got %h", what, expv, gotv); \
		end \
	end

	logic clk;
	logic rst_n;
	logic [P4PU_ADDR_BITS-1:0] regAddr;
	logic regBank;
	logic regDirect;
	logic regWrite;
	logic regRead;
	logic [P4PU_WIDTH-1:0] regWdata;
	logic [P4PU_WIDTH-1:0] regRdata;
	logic regAck;
	logic [P4PU_WIDTH-1:0] pinConfigHigh;
	logic [P4PU_WIDTH-1:0] pinConfigLow;
	logic [P4PU_WIDTH-1:0] openDrain;
	logic [P4PU_WIDTH-1:0] pullupEn;
	int err_total;
	int cmp_count;
	int cycles;
	int n;
	int m;
	int od;
	logic [P4PU_WIDTH-1:0] expv;

	p4pu_top dut_u (
		.clk(clk),
		.rst_n(rst_n),
		.regAddr(regAddr),
		.regBank(regBank),
		.regDirect(regDirect),
		.regWrite(regWrite),
		.regRead(regRead),
		.regWdata(regWdata),
		.regRdata(regRdata),
		.regAck(regAck),
		.pinConfigHigh(pinConfigHigh),
		.pinConfigLow(pinConfigLow),
		.openDrain(openDrain),
		.pullupEn(pullupEn)
	);

	// 20 MHz core clock
	always #25 clk = ~clk;

	// hang guard, far beyond the roughly one hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			stop_test();
		end
	end

	// verdict and end of run
	task automatic stop_test();
		if (err_total == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// one register access; strobes last one cycle, ack looked at in the answer cycle
	task automatic acc(input logic b, input logic [7:0] a, input logic d, input logic w,
		input logic r, input logic [7:0] wd, input logic expAck);
		@(posedge clk);
		#1 regBank = b;
		regAddr = a;
		regDirect = d;
		regWrite = w;
		regRead = r;
		regWdata = wd;
		@(posedge clk);
		#1 regWrite = 1'b0;
		regRead = 1'b0;
		`CHK("ack", expAck, regAck)
	endtask

	// new pin configuration, settled one step after the edge
	task automatic set_cfg(input logic [15:0] cfg, input logic [7:0] odv);
		@(posedge clk);
		#1 {pinConfigHigh, pinConfigLow} = cfg;
		openDrain = odv;
		#1;
	endtask

	// main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{regAddr, regBank, regDirect, regWrite, regRead, regWdata} = '0;
		{pinConfigHigh, pinConfigLow, openDrain} = '0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		`CHK("pull_rst", 8'h00, pullupEn)
		acc(1'b1, 8'hed, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
		`CHK("rd_rst", 8'h00, regRdata)
		acc(1'b1, 8'hed, 1'b1, 1'b1, 1'b0, 8'hff, 1'b1);
		`CHK("pull_ff", 8'hff, pullupEn)
		// accesses that must not reach the register
		acc(1'b0, 8'hed, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
		acc(1'b1, 8'hec, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
		acc(1'b1, 8'hee, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0);
		acc(1'b1, 8'hed, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0);
		`CHK("rd_hold", 8'h00, regRdata)
		`CHK("pull_kept", 8'hff, pullupEn)
		// each bit steers only its own pin, both polarities
		for (n = 0; n < 8; n++) begin
			acc(1'b1, 8'hed, 1'b1, 1'b1, 1'b0, 8'h01 << n, 1'b1);
			`CHK("pull_one", 8'h01 << n, pullupEn)
			acc(1'b1, 8'hed, 1'b1, 1'b1, 1'b0, ~(8'h01 << n), 1'b1);
			`CHK("pull_zero", ~(8'h01 << n), pullupEn)
		end
		// write and read together: read sees the old value
		acc(1'b1, 8'hed, 1'b1, 1'b1, 1'b1, 8'ha5, 1'b1);
		`CHK("rd_old", 8'h7f, regRdata)
		acc(1'b1, 8'hed, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
		`CHK("rd_new", 8'ha5, regRdata)
		acc(1'b1, 8'hed, 1'b1, 1'b1, 1'b0, 8'hff, 1'b1);
		// every mode code on all pins, push-pull and open-drain
		for (m = 0; m < 4; m++) begin
			for (od = 0; od < 2; od++) begin
				set_cfg({8{m[1:0]}}, {8{od[0]}});
				expv = (m == 0 || (m == 3 && od == 1)) ? 8'hff : 8'h00;
				`CHK("pull_mode", expv, pullupEn)
			end
		end
		// field position of each pin
		for (n = 0; n < 8; n++) begin
			set_cfg(16'h0001 << (2 * n), 8'h00);
			`CHK("pull_alt", ~(8'h01 << n), pullupEn)
			// back to input straight from the alternative function
			set_cfg(16'h0000, 8'h00);
			`CHK("pull_back", 8'hff, pullupEn)
			set_cfg(16'h0003 << (2 * n), 8'h00);
			`CHK("pull_pp", ~(8'h01 << n), pullupEn)
			set_cfg(16'h0003 << (2 * n), 8'h01 << n);
			`CHK("pull_od", 8'hff, pullupEn)
		end
		// reset in mid-run clears the register
		set_cfg(16'h0000, 8'h00);
		@(posedge clk);
		#1 rst_n = 1'b0;
		#1;
		`CHK("pull_rst2", 8'h00, pullupEn)
		`CHK("rd_rst2", 8'h00, regRdata)
		@(posedge clk);
		#1 rst_n = 1'b1;
		acc(1'b1, 8'hed, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
		`CHK("rd_after", 8'h00, regRdata)
		stop_test();
	end
endmodule // p4pu_bench

/* p4pu_cfg_if.sv */
// p4pu_cfg_if: carries pin configuration, enable bits and resulting pull-up controls.
// assumes both ends are inside the pull-up block; no clock is carried.
`timescale 1ns/10ps
interface p4pu_cfg_if;
	import p4pu_pkg::*;

	logic [P4PU_WIDTH*P4PU_MODE_BITS-1:0] pinMode;
	logic [P4PU_WIDTH-1:0] openDrain;
	logic [P4PU_WIDTH-1:0] enableBits;
	logic [P4PU_WIDTH-1:0] pullupEn;

	// register side supplies settings, reads back the controls
	modport regs (output pinMode, output openDrain, output enableBits, input pullupEn);
	// gating side turns settings into controls
	modport gate (input pinMode, input openDrain, input enableBits, output pullupEn);
endinterface

/* p4pu_pin_gate.sv */
// p4pu_pin_gate: per-pin gating of the pull-up enable bits by pin configuration.
// assumes pin modes and open-drain selects arrive settled from their own registers.
`timescale 1ns/10ps
module p4pu_pin_gate (
	p4pu_cfg_if.gate cfg
);
	import p4pu_pkg::*;

	logic [P4PU_WIDTH-1:0] pinForced;

	// one gate per pin, bit n of the enable register drives pin n
	for (genvar n = 0; n < P4PU_WIDTH; n++) begin : g_pin
		// alternative function or push-pull output kills the pull-up
		assign pinForced[n] = p4pu_force_off(cfg.pinMode[n*P4PU_MODE_BITS +: P4PU_MODE_BITS],
			cfg.openDrain[n]);
		// bit high asserts the control unless the pin is forced, bit low deasserts it
		assign cfg.pullupEn[n] = cfg.enableBits[n] & ~pinForced[n];
	end

endmodule // p4pu_pin_gate

/* p4pu_pkg.sv */
// p4pu_pkg: constants and pin mode decode for the port 4 pull-up enable block.
// assumes an 8-bit register file in which bank 1 is selected by a single bank bit.
package p4pu_pkg;

	// register geometry
	localparam int P4PU_WIDTH = 8;
	localparam int P4PU_ADDR_BITS = 8;
	localparam int P4PU_MODE_BITS = 2;

	// register placement and reset value
	localparam logic [P4PU_ADDR_BITS-1:0] ADDR_PULLUP_EN = 8'hed;
	localparam logic BANK_PULLUP_EN = 1'h1;
	localparam logic [P4PU_WIDTH-1:0] RESET_PULLUP_EN = 8'h00;

	// pin configuration field codes
	localparam logic [P4PU_MODE_BITS-1:0] MODE_INPUT = 2'h0;
	localparam logic [P4PU_MODE_BITS-1:0] MODE_ALT_A = 2'h1;
	localparam logic [P4PU_MODE_BITS-1:0] MODE_ALT_B = 2'h2;
	localparam logic [P4PU_MODE_BITS-1:0] MODE_OUTPUT = 2'h3;

	// open-drain select value that keeps an output from being push-pull
	localparam logic OPEN_DRAIN_ON = 1'h1;

	// true when the pin's pull-up must be forced off by its configuration
	function automatic logic p4pu_force_off(input logic [P4PU_MODE_BITS-1:0] mode,
		input logic openDrainBit);
		return (mode == MODE_ALT_A) || (mode == MODE_ALT_B) ||
			((mode == MODE_OUTPUT) && (openDrainBit != OPEN_DRAIN_ON));
	endfunction

endpackage

/* p4pu_top.sv */
// p4pu_top: port 4 pull-up enable register and the pull-up controls it steers.
// assumes the core presents direct register accesses one per cycle, synchronous to clk.
`timescale 1ns/10ps
module p4pu_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [p4pu_pkg::P4PU_ADDR_BITS-1:0] regAddr,
	input wire logic regBank,
	input wire logic regDirect,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [p4pu_pkg::P4PU_WIDTH-1:0] regWdata,
	output logic [p4pu_pkg::P4PU_WIDTH-1:0] regRdata,
	output logic regAck,
	input wire logic [p4pu_pkg::P4PU_WIDTH-1:0] pinConfigHigh,
	input wire logic [p4pu_pkg::P4PU_WIDTH-1:0] pinConfigLow,
	input wire logic [p4pu_pkg::P4PU_WIDTH-1:0] openDrain,
	output logic [p4pu_pkg::P4PU_WIDTH-1:0] pullupEn
);
	import p4pu_pkg::*;

	logic [P4PU_WIDTH-1:0] pullupReg;
	logic [P4PU_WIDTH-1:0] next_pullupReg;
	logic [P4PU_WIDTH-1:0] next_regRdata;
	logic next_regAck;
	wire regHit;
	wire writeHit;
	wire readHit;

	p4pu_cfg_if cfgBus ();

	// address decode: bank, address and direct addressing must all agree
	assign regHit = (regBank == BANK_PULLUP_EN) && (regAddr == ADDR_PULLUP_EN)
		&& regDirect;
	assign writeHit = regHit && regWrite;
	assign readHit = regHit && regRead;

	// next values of the register, the read data and the acknowledge
	assign next_pullupReg = writeHit ? regWdata : pullupReg;
	assign next_regRdata = readHit ? pullupReg : regRdata;
	assign next_regAck = regHit && (regWrite || regRead);

	// enable register, cleared by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pullupReg <= RESET_PULLUP_EN;
		end else begin
			pullupReg <= next_pullupReg;
		end
	end

	// read data and acknowledge flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= RESET_PULLUP_EN;
			regAck <= 1'h0;
		end else begin
			regRdata <= next_regRdata;
			regAck <= next_regAck;
		end
	end

	// hand the settings to the per-pin gate
	assign cfgBus.pinMode = {pinConfigHigh, pinConfigLow};
	assign cfgBus.openDrain = openDrain;
	assign cfgBus.enableBits = pullupReg;
	assign pullupEn = cfgBus.pullupEn;

	p4pu_pin_gate uGate (
		.cfg(cfgBus.gate)
	);

	// helper decodes used only by the checks below
	wire [P4PU_MODE_BITS-1:0] modePin0 = pinConfigLow[1:0];
	wire [P4PU_MODE_BITS-1:0] modePin2 = pinConfigLow[5:4];
	wire [P4PU_MODE_BITS-1:0] modePin4 = pinConfigHigh[1:0];
	wire [P4PU_MODE_BITS-1:0] modePin5 = pinConfigHigh[3:2];
	wire [P4PU_MODE_BITS-1:0] modePin7 = pinConfigHigh[7:6];
	wire allInput = ({pinConfigHigh, pinConfigLow} == '0);

	// a direct write in bank 1 at the register's address
	sequence s_writeHit;
		regWrite && regDirect && (regBank == BANK_PULLUP_EN) && (regAddr == ADDR_PULLUP_EN);
	endsequence

	// a direct read in bank 1 at the register's address
	sequence s_readHit;
		regRead && !regWrite && regDirect && (regBank == BANK_PULLUP_EN)
			&& (regAddr == ADDR_PULLUP_EN);
	endsequence

	// no write of any kind reaches the register
	sequence s_noWrite;
		!writeHit;
	endsequence

	// write in bank 1 lands one edge later
	property p_bankWrite;
		@(posedge clk) disable iff (!rst_n)
		s_writeHit |=> (pullupReg == $past(regWdata));
	endproperty
	a_bankWrite: assert property (p_bankWrite)
		else $error("bank 1 write at ed did not update register");

	// same address in the other bank leaves the register alone
	property p_otherBank;
		@(posedge clk) disable iff (!rst_n)
		(regWrite && (regBank != BANK_PULLUP_EN) && !(regBank == BANK_PULLUP_EN && regDirect
			&& regAddr == ADDR_PULLUP_EN)) |=> $stable(pullupReg);
	endproperty
	a_otherBank: assert property (p_otherBank)
		else $error("register changed on a write outside bank 1");

	// other addresses produce no acknowledge
	property p_unmappedNoAck;
		@(posedge clk) disable iff (!rst_n)
		((regWrite || regRead) && (regAddr != ADDR_PULLUP_EN)) |=> !regAck;
	endproperty
	a_unmappedNoAck: assert property (p_unmappedNoAck)
		else $error("acknowledge given for another address");

	// indirect accesses neither write nor acknowledge
	property p_indirect;
		@(posedge clk) disable iff (!rst_n)
		((regWrite || regRead) && !regDirect) |=> ($stable(pullupReg) && !regAck);
	endproperty
	a_indirect: assert property (p_indirect)
		else $error("indirect access reached the register");

	// with every pin in input mode the controls mirror the register bit for bit
	property p_bitMap;
		@(posedge clk) disable iff (!rst_n)
		allInput |-> (pullupEn == pullupReg);
	endproperty
	a_bitMap: assert property (p_bitMap)
		else $error("pull-up controls do not follow register bits");

	// writing a value with all pins input shows it on the pins next cycle
	property p_writeToPins;
		@(posedge clk) disable iff (!rst_n)
		(s_writeHit ##1 allInput) |-> (pullupEn == $past(regWdata));
	endproperty
	a_writeToPins: assert property (p_writeToPins)
		else $error("written value not seen on pull-up controls");

	// a set bit on an input pin asserts the control
	property p_enableOn;
		@(posedge clk) disable iff (!rst_n)
		(pullupReg[0] && (modePin0 == MODE_INPUT)) |-> pullupEn[0];
	endproperty
	a_enableOn: assert property (p_enableOn)
		else $error("pin 0 pull-up not asserted for a set bit");

	// a clear bit always deasserts the control, whatever the mode
	property p_enableOff;
		@(posedge clk) disable iff (!rst_n)
		!pullupReg[7] |-> !pullupEn[7];
	endproperty
	a_enableOff: assert property (p_enableOff)
		else $error("pin 7 pull-up asserted for a clear bit");

	// pin 7 follows its bit in input mode over a write
	property p_pin7Follow;
		@(posedge clk) disable iff (!rst_n)
		(s_writeHit ##1 (modePin7 == MODE_INPUT)) |-> (pullupEn[7] == $past(regWdata[7]));
	endproperty
	a_pin7Follow: assert property (p_pin7Follow)
		else $error("pin 7 pull-up does not follow bit 7");

	// alternative functions force the pull-up off
	property p_altForced;
		@(posedge clk) disable iff (!rst_n)
		((modePin4 == MODE_ALT_A) || (modePin5 == MODE_ALT_B)) |->
			(((modePin4 != MODE_ALT_A) || !pullupEn[4]) && ((modePin5 != MODE_ALT_B) || !pullupEn[5]));
	endproperty
	a_altForced: assert property (p_altForced)
		else $error("pull-up left on for an alternative function pin");

	// push-pull output forces off, open-drain output honours the bit
	property p_outputMode;
		@(posedge clk) disable iff (!rst_n)
		(modePin2 == MODE_OUTPUT) |->
			(pullupEn[2] == (pullupReg[2] && (openDrain[2] == OPEN_DRAIN_ON)));
	endproperty
	a_outputMode: assert property (p_outputMode)
		else $error("pin 2 output mode pull-up wrong");

	// leaving an alternative function restores the stored bit at once
	property p_restore;
		@(posedge clk) disable iff (!rst_n)
		((modePin4 == MODE_ALT_A) ##1 ((modePin4 == MODE_INPUT) && !writeHit))
			|-> (pullupEn[4] == pullupReg[4]);
	endproperty
	a_restore: assert property (p_restore)
		else $error("pin 4 pull-up not restored after leaving alternative mode");

	// register is clear on the first edge after reset
	property p_resetClear;
		@(posedge clk) disable iff (!rst_n)
		!$past(rst_n) |-> (pullupReg == RESET_PULLUP_EN);
	endproperty
	a_resetClear: assert property (p_resetClear)
		else $error("register not cleared by reset");

	// a read returns the stored value and is acknowledged one edge later
	property p_readBack;
		@(posedge clk) disable iff (!rst_n)
		s_readHit |=> (regAck && (regRdata == $past(pullupReg)));
	endproperty
	a_readBack: assert property (p_readBack)
		else $error("read did not return the stored value");

	// without a write the register holds for the following cycles
	property p_holds;
		@(posedge clk) disable iff (!rst_n)
		(s_noWrite [*3]) |=> (pullupReg == $past(pullupReg, 3));
	endproperty
	a_holds: assert property (p_holds)
		else $error("register changed without a write");

endmodule // p4pu_top
